// ---- xz_exec.sv ----
// Exclusive-OR and zero-extend execution with hidden write state accounting.
`timescale 1ns/1ps
`include "xz_map.svh"
module xz_exec
  import xz_pkg::*;
#(
  parameter int DATA_W = `XZ_DATA_W,
  parameter int FS_W = `XZ_FS_W,
  parameter int MAX_HIDDEN = `XZ_MAX_HIDDEN,
  parameter int HIDDEN_W = `XZ_HIDDEN_W,
  parameter int STATE_CYCLES = `XZ_STATE_CYCLES
) (
  input wire logic sys_clk,
  input wire logic rstn,
  input wire logic [3:0] addr,
  input wire logic [31:0] wdata,
  input wire logic wr,
  input wire logic rd,
  output logic [31:0] rdata,
  input wire logic exec_valid,
  input wire exec_req_type exec_req,
  input wire flags_type flags_in,
  output logic exec_done,
  output logic [31:0] result,
  output flags_type flags_out,
  input wire logic [HIDDEN_W-1:0] hidden_writes,
  input wire logic bus_request,
  output logic bus_grant,
  input wire logic bus_delay,
  output logic state_tick
);
  initial begin
    if (DATA_W != 32) begin
      $error("data path is built for 32-bit words");
    end
    if (MAX_HIDDEN < 1 || MAX_HIDDEN >= (1 << HIDDEN_W)) begin
      $error("hidden state counter too narrow");
    end
    if (STATE_CYCLES < 1) begin
      $error("machine state must last at least one clock");
    end
  end

  logic [FS_W-1:0] field_size_a_reg;
  logic [FS_W-1:0] field_size_b_reg;
  logic cache_en_reg;
  logic [HIDDEN_W-1:0] hidden_reg;
  logic [HIDDEN_W-1:0] hidden_next;
  logic [15:0] div_reg;
  logic [31:0] exec_count_reg;
  logic [31:0] stall_count_reg;
  logic [31:0] hit_mem_reg;
  logic [31:0] fetch_mem_reg;
  logic [FS_W-1:0] field_width;
  logic [DATA_W-1:0] field_mask;
  logic [31:0] result_next;
  flags_type flags_next;
  logic bus_busy;
  logic [HIDDEN_W-1:0] hidden_load;

  // A machine state is one tick; at this clock rate that is one cycle.
  assign state_tick = (div_reg == 16'(STATE_CYCLES - 1));

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      div_reg <= 16'h0000;
    end else if (state_tick) begin
      div_reg <= 16'h0000;
    end else begin
      div_reg <= div_reg + 16'h0001;
    end
  end

  // Register port.
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      field_size_a_reg <= FS_W'(`XZ_FS_RESET);
      field_size_b_reg <= FS_W'(`XZ_FS_RESET);
      cache_en_reg <= 1'b1;
    end else if (wr) begin
      unique case (addr)
        `XZ_ADDR_FS_A: field_size_a_reg <= wdata[FS_W-1:0];
        `XZ_ADDR_FS_B: field_size_b_reg <= wdata[FS_W-1:0];
        `XZ_ADDR_CTRL: cache_en_reg <= wdata[`XZ_CTRL_CACHE_EN];
        default: ;
      endcase
    end
  end

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      rdata <= 32'h0000_0000;
    end else if (rd) begin
      unique case (addr)
        `XZ_ADDR_FS_A: rdata <= 32'(field_size_a_reg);
        `XZ_ADDR_FS_B: rdata <= 32'(field_size_b_reg);
        `XZ_ADDR_CTRL: rdata <= 32'(cache_en_reg);
        `XZ_ADDR_STATUS: rdata <= {27'h0, bus_busy, hidden_reg};
        `XZ_ADDR_COUNT: rdata <= exec_count_reg;
        `XZ_ADDR_STALLS: rdata <= stall_count_reg;
        `XZ_ADDR_HIT_MEM: rdata <= hit_mem_reg;
        `XZ_ADDR_FETCH_MEM: rdata <= fetch_mem_reg;
        default: rdata <= 32'h0000_0000;
      endcase
    end else begin
      rdata <= 32'h0000_0000;
    end
  end

  // Field selector picks the field size setting.
  assign field_width = exec_req.field_sel ? field_size_b_reg : field_size_a_reg;

  xz_field_mask #(
    .DATA_W(DATA_W),
    .FS_W(FS_W)
  ) u_mask (
    .width(field_width),
    .mask(field_mask)
  );

  // Only Z is recomputed; other flags pass through untouched.
  always_comb begin
    result_next = exec_req.dst;
    flags_next = flags_in;
    unique case (exec_req.op)
      op_xor_reg: begin
        result_next = exec_req.src ^ exec_req.dst;
        flags_next.z = (result_next == 32'h0000_0000);
      end
      op_xor_immediate: begin
        result_next = exec_req.long_immediate ^ exec_req.dst;
        flags_next.z = (result_next == 32'h0000_0000);
      end
      op_zero_extend: begin
        result_next = exec_req.dst & field_mask;
        flags_next.z = (result_next == 32'h0000_0000);
      end
      op_none: begin
        result_next = exec_req.dst;
      end
    endcase
  end

  // Executions are taken on a machine state tick only.
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      result <= 32'h0000_0000;
      flags_out <= '0;
      exec_done <= 1'b0;
    end else begin
      exec_done <= exec_valid && state_tick;
      if (exec_valid && state_tick) begin
        result <= result_next;
        flags_out <= flags_next;
      end
    end
  end

  // Trailing writes are clamped to the per-instruction ceiling.
  assign hidden_load = (hidden_writes > HIDDEN_W'(MAX_HIDDEN)) ?
                       HIDDEN_W'(MAX_HIDDEN) : hidden_writes;

  // External delays (wait states, refresh, host, hold) freeze the drain.
  always_comb begin
    hidden_next = hidden_reg;
    if (state_tick && !bus_delay && hidden_reg != '0) begin
      hidden_next = hidden_reg - HIDDEN_W'(1);
    end
    if (exec_done && !bus_busy) begin
      hidden_next = hidden_load;
    end
  end

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      hidden_reg <= '0;
    end else begin
      hidden_reg <= hidden_next;
    end
  end

  assign bus_busy = (hidden_reg != '0) || bus_delay;
  assign bus_grant = bus_request && !bus_busy;

  // Counters give software a view of executed work and stall states.
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      exec_count_reg <= 32'h0000_0000;
      stall_count_reg <= 32'h0000_0000;
    end else begin
      if (exec_done) begin
        exec_count_reg <= exec_count_reg + 32'h0000_0001;
      end
      if (bus_request && bus_busy && state_tick) begin
        stall_count_reg <= stall_count_reg + 32'h0000_0001;
      end
    end
  end
  // Granted memory states are split by cache mode. With the cache on, they are data
  // transfers or miss fills; with it off they include word fetches. A miss can cost
  // more than a disabled-cache fetch, so neither count bounds the other.
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      hit_mem_reg <= 32'h0000_0000;
      fetch_mem_reg <= 32'h0000_0000;
    end else if (bus_grant && state_tick) begin
      if (cache_en_reg) begin
        hit_mem_reg <= hit_mem_reg + 32'h0000_0001;
      end else begin
        fetch_mem_reg <= fetch_mem_reg + 32'h0000_0001;
      end
    end
  end
endmodule : xz_exec

// ---- xz_map.svh ----
// Offsets, field layout and timing constants for the xor/zero_extend_op execution block.
`ifndef XZ_MAP_SVH
`define XZ_MAP_SVH
`define XZ_DATA_W 32
`define XZ_FS_W 6
`define XZ_MAX_HIDDEN 9
`define XZ_HIDDEN_W 4
`define XZ_STATE_NS 100
`define XZ_CLK_MHZ 10
`define XZ_STATE_CYCLES ((`XZ_STATE_NS * `XZ_CLK_MHZ + 999) / 1000)
`define XZ_FS_RESET 6'h20
`define XZ_ADDR_FS_A 4'h0
`define XZ_ADDR_FS_B 4'h1
`define XZ_ADDR_CTRL 4'h2
`define XZ_ADDR_STATUS 4'h3
`define XZ_ADDR_COUNT 4'h4
`define XZ_ADDR_STALLS 4'h5
`define XZ_ADDR_HIT_MEM 4'h6
`define XZ_ADDR_FETCH_MEM 4'h7
`define XZ_CTRL_CACHE_EN 0
`endif

// ---- xz_pkg.sv ----
// Types shared by the xor/zero_extend_op execution block.
package xz_pkg;
  typedef enum logic [1:0] {
    op_xor_reg,
    op_xor_immediate,
    op_zero_extend,
    op_none
  } op_type;

  typedef struct packed {
    logic n;
    logic c;
    logic z;
    logic v;
  } flags_type;

  typedef struct packed {
    op_type op;
    logic field_sel;
    logic [31:0] src;
    logic [31:0] dst;
    logic [31:0] long_immediate;
  } exec_req_type;
endpackage : xz_pkg

// ---- xz_field_mask.sv ----
// Builds the mask that keeps a right-justified field of a given width.
`timescale 1ns/1ps
module xz_field_mask #(
  parameter int DATA_W = 32,
  parameter int FS_W = 6
) (
  input wire logic [FS_W-1:0] width,
  output logic [DATA_W-1:0] mask
);
  initial begin
    if (DATA_W < 1 || (1 << FS_W) <= DATA_W) begin
      $error("field width port cannot express the data width");
    end
  end

  // A width of zero stands for the full word, as does any width of 32 or more.
  always_comb begin
    mask = '0;
    for (int i = 0; i < DATA_W; i++) begin
      if (width == '0 || i < int'(width)) begin
        mask[i] = 1'b1;
      end
    end
  end
endmodule : xz_field_mask

// ---- xz_chk.sv ----
// Port assertions for the xor/zero_extend_op execution block.
`timescale 1ns/1ps
module xz_chk
  import xz_pkg::*;
#(parameter int HIDDEN_W = 4)
(
  input wire logic sys_clk,
  input wire logic rstn,
  input wire logic exec_valid,
  input wire exec_req_type exec_req,
  input wire flags_type flags_in,
  input wire logic exec_done,
  input wire logic [31:0] result,
  input wire flags_type flags_out,
  input wire logic [HIDDEN_W-1:0] hidden_writes,
  input wire logic bus_request,
  input wire logic bus_grant,
  input wire logic bus_delay,
  input wire logic state_tick
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rstn);
  a_state_tick: assert property (state_tick) else $error("no tick");
  a_done_next: assert property (exec_valid |=> exec_done) else $error("no done");
  a_xor_reg: assert property (exec_valid && exec_req.op == op_xor_reg |=>
    result == ($past(exec_req.src) ^ $past(exec_req.dst))) else $error("xor");
  a_xor_imm: assert property (exec_valid && exec_req.op == op_xor_immediate |=>
    result == ($past(exec_req.long_immediate) ^ $past(exec_req.dst))) else $error("xor_immediate_op");
  a_flags_kept: assert property (exec_valid |=>
    ((flags_out ^ $past(flags_in)) & 4'hd) == 4'h0) else $error("flags");
  a_zero_flag: assert property (exec_done |->
    flags_out.z == (result == 32'h0)) else $error("z");
  a_zero_extend_op_clear: assert property (exec_valid && exec_req.op == op_zero_extend |=>
    (result & ~$past(exec_req.dst)) == 32'h0) else $error("zero_extend_op");
  a_delay_block: assert property (bus_delay |-> !bus_grant) else $error("delay");
  a_grant_cause: assert property (bus_grant |-> bus_request) else $error("grant");
  a_hidden_hold: assert property (exec_done && hidden_writes == 9 && bus_grant |=>
    !bus_grant [*8]) else $error("hidden");
  cover property (exec_done && flags_out.z);
  cover property (bus_request && !bus_grant && !bus_delay);
  cover property (exec_done && hidden_writes == 9);
endmodule : xz_chk
bind xz_exec xz_chk #(.HIDDEN_W(HIDDEN_W)) chk_i (.sys_clk, .rstn, .exec_valid,
  .exec_req, .flags_in, .exec_done, .result, .flags_out, .hidden_writes, .bus_request,
  .bus_grant, .bus_delay, .state_tick);

// ---- xz_mem_model.sv ----
// Memory controller and fetch path model that asks for the bus and adds wait states.
`timescale 1ns/1ps
module xz_mem_model (
  input wire logic sys_clk,
  input wire logic want,
  input wire logic slow,
  input wire logic bus_grant,
  output logic bus_request,
  output logic bus_delay
);
  initial begin
    bus_request = 1'b0;
    bus_delay = 1'b0;
  end
  // A request stays up until granted, so a stall is never hidden by a drop.
  always @(posedge sys_clk) begin
    bus_request <= want | (bus_request & !bus_grant);
    bus_delay <= slow;
  end
endmodule : xz_mem_model

// ---- testbench.sv ----
// Self-checking bench for the xor/zero_extend_op execution block.
`timescale 1ns/1ps
module testbench;
  import xz_pkg::*;
  logic sys_clk, rstn, wr, rd, exec_valid, exec_done, bus_request, bus_grant, bus_delay;
  logic state_tick, want, slow;
  logic [3:0] addr, hidden_writes;
  logic [31:0] wdata, rdata, result;
  exec_req_type exec_req;
  flags_type flags_in, flags_out;
  int mismatches = 0, n_compared = 0, cycles = 0, n;
  logic [31:0] pat[3] = '{32'h0, 32'haaaaaaaa, 32'hffffffff};
  logic [31:0] fsz[3] = '{32'h20, 32'h1f, 32'h1};
  logic [31:0] zx[3] = '{32'hffffffff, 32'h7fffffff, 32'h1};
  xz_exec dut (.sys_clk, .rstn, .addr, .wdata, .wr, .rd, .rdata, .exec_valid, .exec_req,
    .flags_in, .exec_done, .result, .flags_out, .hidden_writes, .bus_request, .bus_grant,
    .bus_delay, .state_tick);
  xz_mem_model mem (.sys_clk, .want, .slow, .bus_grant, .bus_request, .bus_delay);
  initial begin
    sys_clk = 1'b0;
    forever #50 sys_clk = ~sys_clk;
  end
  task automatic give_verdict();
    $display("compared %0d mismatches %0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : give_verdict
  always @(posedge sys_clk) begin
    cycles <= cycles + 1;
    if (cycles == 3000) begin
      mismatches = mismatches + 1;
      give_verdict();
    end
  end
  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    n_compared++;
    if (got !== exp) begin
      mismatches++;
      $display("[ERR] %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk
  task automatic wr_reg(input logic [3:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge sys_clk);
    wr <= 1'b0;
  endtask : wr_reg
  task automatic rd_reg(input logic [3:0] a, input logic [31:0] exp);
    @(posedge sys_clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge sys_clk);
    rd <= 1'b0;
    #1 chk("rdata", exp, rdata);
  endtask : rd_reg
  // Odd hidden counts come with N, C, V set, so stuck flags show either way.
  task automatic run(input op_type op, input logic sel, input logic [31:0] d,
    input logic [31:0] s, input logic [3:0] hw, input logic [31:0] r, input logic z);
    @(posedge sys_clk);
    exec_valid <= 1'b1;
    exec_req <= '{op, sel, s, d, s};
    flags_in <= hw[0] ? 4'hd : 4'h2;
    hidden_writes <= hw;
    @(posedge sys_clk);
    exec_valid <= 1'b0;
    #1 chk("result", r, result);
    chk("flags", {28'h0, (hw[0] ? 4'hd : 4'h0) | {2'b00, z, 1'b0}}, {28'h0, flags_out});
    chk("done", 32'h1, {31'h0, exec_done});
  endtask : run
  task automatic stalls(input int exp);
    n = 0;
    repeat (12) begin
      @(posedge sys_clk);
      #1 if (bus_grant !== 1'b1) n++;
    end
    chk("stalls", exp, n);
  endtask : stalls
  initial begin
    {rstn, wr, rd, exec_valid, want, slow} = 6'h00;
    addr = 4'h0;
    wdata = 32'h0;
    exec_req = '0;
    flags_in = 4'h0;
    hidden_writes = 4'h0;
    repeat (8) @(posedge sys_clk);
    rstn <= 1'b1;
    rd_reg(4'h0, 32'h20);
    rd_reg(4'h1, 32'h20);
    rd_reg(4'h9, 32'h0);
    foreach (pat[i]) begin
      run(op_xor_reg, 1'b0, pat[i], 32'hffffffff, 4'h0, ~pat[i], pat[i] == '1);
      run(op_xor_immediate, 1'b0, pat[i], 32'h0, 4'h1, pat[i], pat[i] == '0);
    end
    wr_reg(4'h1, 32'h10);
    foreach (fsz[i]) begin
      wr_reg(4'h0, fsz[i]);
      run(op_zero_extend, 1'b0, 32'hffffffff, 32'h0, 4'h1, zx[i], 1'b0);
    end
    rd_reg(4'h0, 32'h1);
    run(op_zero_extend, 1'b1, 32'hffff0000, 32'h0, 4'h0, 32'h0, 1'b1);
    @(posedge sys_clk);
    want <= 1'b1;
    repeat (2) @(posedge sys_clk);
    run(op_xor_reg, 1'b0, 32'h1, 32'h1, 4'h9, 32'h0, 1'b1);
    stalls(9);
    run(op_xor_reg, 1'b0, 32'h3, 32'h1, 4'h9, 32'h2, 1'b0);
    run(op_xor_reg, 1'b0, 32'h3, 32'h3, 4'h0, 32'h0, 1'b1);
    stalls(7);
    @(posedge sys_clk);
    slow <= 1'b1;
    repeat (3) @(posedge sys_clk);
    #1 chk("grant", 32'h0, {31'h0, bus_grant});
    @(posedge sys_clk);
    slow <= 1'b0;
    repeat (3) @(posedge sys_clk);
    #1 chk("grant", 32'h1, {31'h0, bus_grant});
    rd_reg(4'h4, 32'hd);
    rd_reg(4'h3, 32'h0);
    rd_reg(4'h7, 32'h0);
    give_verdict();
  end
endmodule : testbench
